// >>> core/rffc_pkg.sv
// Shared constants for the fraction and fastlock control block
package rffc_pkg;
    // Serial word layout
    localparam int WORD_W = 24;
    localparam int ADDR_W = 4;
    localparam int DATA_LSB = 4;

    // Destination codes in the low nibble of each word
    localparam logic [3:0] ADDR_NUM_LO = 4'h1;
    localparam logic [3:0] ADDR_DEN_LO = 4'h3;
    localparam logic [3:0] ADDR_FRAC_HI = 4'hb;
    localparam logic [3:0] ADDR_FASTLOCK = 4'hd;
    localparam logic [3:0] ADDR_LOCKDET = 4'hf;

    // Fraction fields
    localparam int FRAC_LO_W = 12;
    localparam int FRAC_HI_W = 10;
    localparam int FRAC_W = 22;
    localparam int FRAC_LO_LSB = 4;
    localparam int WIDE_BIT = 23;
    localparam int FD_HI_LSB = 14;
    localparam int FN_HI_LSB = 4;

    // Fastlock configuration fields
    localparam int TOC_W = 14;
    localparam int TOC_LSB = 4;
    localparam int CPF_W = 4;
    localparam int CPF_LSB = 18;
    localparam int CSR_W = 2;
    localparam int CSR_LSB = 22;
    localparam int GAIN_W = 5;
    localparam int CNT_W = 15;

    // Lock detect control field
    localparam int QUARTER_BIT = 13;
    localparam logic [1:0] QUARTER_LAST = 2'h3;

    // Timeout word meanings
    localparam logic [13:0] TOC_FLOAT = 14'h0000;
    localparam logic [13:0] TOC_MANUAL = 14'h0001;
    localparam logic [13:0] TOC_LOW = 14'h0002;
    localparam logic [13:0] TOC_HIGH = 14'h0003;
    localparam logic [13:0] TOC_FL_MIN = 14'h0004;

    // Cycle slip sample rate shifts
    localparam logic [3:0] CSR_SHIFT_OFF = 4'h0;
    localparam logic [3:0] CSR_SHIFT_HALF = 4'h1;
    localparam logic [3:0] CSR_SHIFT_QUARTER = 4'h2;
    localparam logic [3:0] CSR_SHIFT_SIXTEENTH = 4'h4;

    // Steady-state gain code shown outside fastlock
    localparam logic [4:0] GAIN_STEADY = 5'h00;
endpackage

// >>> core/rffc_if.sv
`timescale 1ns/1ns
// Link between the register side and the fastlock timer
interface rffc_if;
    logic load;
    logic tick;
    logic [13:0] timeout;
    logic active;

    modport ctrl (
        output load,
        output tick,
        output timeout,
        input active
    );
    modport timer (
        input load,
        input tick,
        input timeout,
        output active
    );
endinterface

// >>> core/rffc_timer.sv
`timescale 1ns/1ns
// Fastlock timeout counter in comparison cycles
module rffc_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control link
    rffc_if.timer tif
);
    typedef struct packed {
        logic [rffc_pkg::CNT_W-1:0] cnt;
        logic active;
    } rffc_timer_st_t;

    rffc_timer_st_t st_q;
    rffc_timer_st_t st_d;
    logic [rffc_pkg::CNT_W-1:0] cnt_m1;

    // Load twice the timeout, count ticks down, drop at zero
    always_comb begin
        st_d = st_q;
        cnt_m1 = st_q.cnt - 15'h0001;
        if (tif.load) begin
            st_d.cnt = {tif.timeout, 1'b0}; // see [RULE7]
            st_d.active = 1'b1;
        end else if (tif.tick && st_q.cnt != '0) begin
            st_d.cnt = cnt_m1; // see [RULE14]
            st_d.active = (cnt_m1 != '0);
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tif.active = st_q.active;

    // Checks
    load_twice_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE7]
        tif.load |=> st_q.cnt == {$past(tif.timeout), 1'b0} && st_q.active)
        else $error("timer not loaded with twice the timeout");
    expire_drop_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE14]
        (!tif.load && tif.tick && st_q.cnt == 15'h0001) |=> !st_q.active)
        else $error("fastlock did not end at expiry");
    hold_count_a: assert property (@(posedge mclk) disable iff (rst) // see [RULE7]
        (!tif.load && !tif.tick) |=> $stable(st_q.cnt))
        else $error("timer moved without a comparison tick");
    expiry_c: cover property (@(posedge mclk) disable iff (rst)
        st_q.active ##1 !st_q.active);
endmodule // rffc_timer

// >>> core/rffc_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] Narrow mode: 12-bit numerator, upper ten numerator bits ignored.
// [RULE2] Wide mode: numerator is upper ten bits joined above lower twelve.
// [RULE3] Denominator follows the same narrow or wide selection.
// [RULE4] Host writes upper fields as zero for values below 4096.
// [RULE5] Timeout 0 to 3 disables fastlock; pin is a plain output. Code still forces fastlock at timeout 1.
// [RULE6] Timeout 4 and up enables fastlock; pin shows fastlock state.
// [RULE7] Fastlock lasts twice the timeout word in comparison cycles.
// [RULE8] Timeout 0 floats, 1 low plus forced fastlock, 2 low, 3 high.
// [RULE9] In fastlock pump gain is code plus one times unit current.
// [RULE10] Cycle slip field: off, then rate one half, quarter, sixteenth.
// [RULE11] Quarter-rate bit divides lock detect comparison events by four.
// [RULE12] Host sets quarter-rate above 20 MHz comparison with lock detect.
// [RULE13] Code 1011 word carries denominator and numerator upper fields.
// [RULE14] Frequency write loads timer; expiry returns to steady-state gain.
// [RULE15] Low nibble of each word selects register; upper twenty bits latch.
module rffc_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial programming port
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_le,
    // Phase detector comparison event
    input wire logic pd_tick,
    // Fraction outputs
    output logic [21:0] rf_frac_numerator,
    output logic [21:0] rf_frac_denominator,
    // Fastlock outputs
    output logic rf_fastlock_active,
    output logic [4:0] rf_fastlock_pump_gain,
    output logic cycle_slip_reduce_en,
    output logic [3:0] cycle_slip_reduce_shift,
    // Fastlock pin
    output logic rf_fastlock_pin_o,
    output logic rf_fastlock_pin_oe,
    // Lock detect comparison event
    output logic lockdet_tick
);
    typedef struct packed {
        logic sclk_prev;
        logic le_prev;
        logic [23:0] shift;
        logic wide;
        logic [11:0] fn_lo;
        logic [11:0] fd_lo;
        logic [9:0] fn_hi;
        logic [9:0] fd_hi;
        logic [13:0] toc;
        logic [3:0] cpf;
        logic [1:0] cycle_slip_reduce;
        logic quarter;
        logic [1:0] ld_div;
        logic ld_tick;
        logic [21:0] num;
        logic [21:0] den;
        logic fl_on;
        logic [4:0] gain;
        logic pin_o;
        logic pin_oe;
        logic csr_en;
        logic [3:0] csr_shift;
        logic load;
    } rffc_ctrl_st_t;

    rffc_ctrl_st_t st_q;
    rffc_ctrl_st_t st_d;
    logic le_rise;
    logic manual;

    rffc_if tif ();

    // Destination match on the low nibble of a word
    function automatic logic addr_hit(input logic [23:0] word, input logic [3:0] code);
        return word[rffc_pkg::ADDR_W-1:0] == code;
    endfunction

    // Join the fraction halves per selected width
    function automatic logic [21:0] frac_join(input logic wide, input logic [9:0] hi,
                                              input logic [11:0] lo);
        return wide ? {hi, lo} : {10'h000, lo};
    endfunction

    // Fastlock timer
    rffc_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .tif(tif.timer)
    );

    // Timer link
    assign tif.load = st_q.load;
    assign tif.tick = pd_tick;
    assign tif.timeout = st_q.toc;

    // Next state
    always_comb begin
        st_d = st_q;
        le_rise = ser_le && !st_q.le_prev;
        manual = (st_q.toc == rffc_pkg::TOC_MANUAL);
        st_d.sclk_prev = ser_clk;
        st_d.le_prev = ser_le;
        st_d.load = 1'b0;

        // Shift in on each serial clock rise
        if (ser_clk && !st_q.sclk_prev) begin
            st_d.shift = {st_q.shift[22:0], ser_data};
        end

        // Latch word on enable rise, routed by low nibble
        if (le_rise) begin
            if (addr_hit(st_q.shift, rffc_pkg::ADDR_NUM_LO)) begin // see [RULE15]
                st_d.fn_lo = st_q.shift[rffc_pkg::FRAC_LO_LSB +: rffc_pkg::FRAC_LO_W];
                st_d.wide = st_q.shift[rffc_pkg::WIDE_BIT];
                st_d.load = (st_q.toc >= rffc_pkg::TOC_FL_MIN); // see [RULE14]
            end else if (addr_hit(st_q.shift, rffc_pkg::ADDR_DEN_LO)) begin
                st_d.fd_lo = st_q.shift[rffc_pkg::FRAC_LO_LSB +: rffc_pkg::FRAC_LO_W];
            end else if (addr_hit(st_q.shift, rffc_pkg::ADDR_FRAC_HI)) begin
                st_d.fd_hi = st_q.shift[rffc_pkg::FD_HI_LSB +: rffc_pkg::FRAC_HI_W]; // see [RULE13]
                st_d.fn_hi = st_q.shift[rffc_pkg::FN_HI_LSB +: rffc_pkg::FRAC_HI_W];
            end else if (addr_hit(st_q.shift, rffc_pkg::ADDR_FASTLOCK)) begin
                st_d.toc = st_q.shift[rffc_pkg::TOC_LSB +: rffc_pkg::TOC_W];
                st_d.cpf = st_q.shift[rffc_pkg::CPF_LSB +: rffc_pkg::CPF_W];
                st_d.cycle_slip_reduce = st_q.shift[rffc_pkg::CSR_LSB +: rffc_pkg::CSR_W];
            end else if (addr_hit(st_q.shift, rffc_pkg::ADDR_LOCKDET)) begin
                st_d.quarter = st_q.shift[rffc_pkg::QUARTER_BIT];
            end
        end

        // Fraction outputs per width select
        st_d.num = frac_join(st_q.wide, st_q.fn_hi, st_q.fn_lo); // see [RULE1] [RULE2]
        st_d.den = frac_join(st_q.wide, st_q.fd_hi, st_q.fd_lo); // see [RULE3]

        // Fastlock state: forced in manual, timed when enabled
        st_d.fl_on = manual || (st_q.toc >= rffc_pkg::TOC_FL_MIN && tif.active); // see [RULE6]

        // Pump gain during fastlock, steady-state otherwise
        if (st_d.fl_on) begin
            st_d.gain = {1'b0, st_q.cpf} + 5'h01; // see [RULE9]
        end else begin
            st_d.gain = rffc_pkg::GAIN_STEADY; // see [RULE14]
        end

        // Fastlock pin function
        case (st_q.toc)
            rffc_pkg::TOC_FLOAT: begin
                st_d.pin_oe = 1'b0; // see [RULE5] [RULE8]
                st_d.pin_o = 1'b0;
            end
            rffc_pkg::TOC_MANUAL: begin
                st_d.pin_oe = 1'b1; // see [RULE8]
                st_d.pin_o = 1'b0;
            end
            rffc_pkg::TOC_LOW: begin
                st_d.pin_oe = 1'b1;
                st_d.pin_o = 1'b0;
            end
            rffc_pkg::TOC_HIGH: begin
                st_d.pin_oe = 1'b1;
                st_d.pin_o = 1'b1;
            end
            default: begin
                st_d.pin_oe = 1'b1; // see [RULE6]
                st_d.pin_o = st_d.fl_on;
            end
        endcase

        // Cycle slip reduction decode
        st_d.csr_en = (st_q.cycle_slip_reduce != 2'h0); // see [RULE10]
        case (st_q.cycle_slip_reduce)
            2'h1: st_d.csr_shift = rffc_pkg::CSR_SHIFT_HALF;
            2'h2: st_d.csr_shift = rffc_pkg::CSR_SHIFT_QUARTER;
            2'h3: st_d.csr_shift = rffc_pkg::CSR_SHIFT_SIXTEENTH;
            default: st_d.csr_shift = rffc_pkg::CSR_SHIFT_OFF;
        endcase

        // Lock detect events, optionally one in four
        if (!st_q.quarter) begin
            st_d.ld_div = 2'h0;
            st_d.ld_tick = pd_tick;
        end else begin
            st_d.ld_tick = pd_tick && (st_q.ld_div == rffc_pkg::QUARTER_LAST); // see [RULE11]
            if (pd_tick) begin
                st_d.ld_div = st_q.ld_div + 2'h1;
            end
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign rf_frac_numerator = st_q.num;
    assign rf_frac_denominator = st_q.den;
    assign rf_fastlock_active = st_q.fl_on;
    assign rf_fastlock_pump_gain = st_q.gain;
    assign cycle_slip_reduce_en = st_q.csr_en;
    assign cycle_slip_reduce_shift = st_q.csr_shift;
    assign rf_fastlock_pin_o = st_q.pin_o;
    assign rf_fastlock_pin_oe = st_q.pin_oe;
    assign lockdet_tick = st_q.ld_tick;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    num_narrow_a: assert property (!st_q.wide |=> // see [RULE1]
        rf_frac_numerator[21:12] == 10'h000)
        else $error("narrow numerator has upper bits set");
    num_wide_a: assert property (st_q.wide |=> // see [RULE2]
        rf_frac_numerator == {$past(st_q.fn_hi), $past(st_q.fn_lo)})
        else $error("wide numerator not joined");
    den_width_a: assert property (1'b1 |=> // see [RULE3]
        rf_frac_denominator == ($past(st_q.wide) ? {$past(st_q.fd_hi), $past(st_q.fd_lo)}
                                                 : {10'h000, $past(st_q.fd_lo)}))
        else $error("denominator width wrong");
    pin_float_a: assert property (st_q.toc == rffc_pkg::TOC_FLOAT |=> // see [RULE5]
        !rf_fastlock_pin_oe)
        else $error("pin driven with timeout zero");
    pin_fl_a: assert property (st_q.toc >= rffc_pkg::TOC_FL_MIN |=> // see [RULE6]
        rf_fastlock_pin_oe && rf_fastlock_pin_o == rf_fastlock_active)
        else $error("pin does not show fastlock");
    manual_force_a: assert property (st_q.toc == rffc_pkg::TOC_MANUAL |=> // see [RULE8]
        rf_fastlock_pin_oe && !rf_fastlock_pin_o && rf_fastlock_active)
        else $error("manual mode not forced");
    pin_level_a: assert property (st_q.toc == rffc_pkg::TOC_HIGH |=> // see [RULE8]
        rf_fastlock_pin_oe && rf_fastlock_pin_o && !rf_fastlock_active)
        else $error("timeout three not driving high");
    pump_gain_a: assert property (rf_fastlock_active |-> // see [RULE9]
        rf_fastlock_pump_gain == {1'b0, $past(st_q.cpf)} + 5'h01)
        else $error("fastlock gain not code plus one");
    steady_gain_a: assert property (!rf_fastlock_active |-> // see [RULE14]
        rf_fastlock_pump_gain == rffc_pkg::GAIN_STEADY)
        else $error("gain not steady outside fastlock");
    csr_decode_a: assert property (st_q.cycle_slip_reduce == 2'h3 |=> // see [RULE10]
        cycle_slip_reduce_en && cycle_slip_reduce_shift == rffc_pkg::CSR_SHIFT_SIXTEENTH)
        else $error("cycle slip sixteenth not decoded");
    quarter_gap_a: assert property ((lockdet_tick && st_q.quarter // see [RULE11]
        && $past(st_q.quarter)) |=> !lockdet_tick || !$past(st_q.quarter))
        else $error("lock detect events not divided");
    full_rate_a: assert property (!st_q.quarter |=> lockdet_tick == $past(pd_tick)) // see [RULE11]
        else $error("full-rate lock detect event lost");
    hi_fields_a: assert property ((le_rise // see [RULE13]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_FRAC_HI))
        |=> st_q.fd_hi == $past(st_q.shift[23:14]) && st_q.fn_hi == $past(st_q.shift[13:4]))
        else $error("upper fraction fields not latched");
    decode_toc_a: assert property ((le_rise // see [RULE15]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_FASTLOCK))
        |=> st_q.toc == $past(st_q.shift[17:4]))
        else $error("timeout word not latched");
    load_pulse_a: assert property ((le_rise // see [RULE14]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_NUM_LO)
        && st_q.toc >= rffc_pkg::TOC_FL_MIN) |=> st_q.load ##1 !st_q.load)
        else $error("frequency write did not start fastlock");

    // Field latching per destination code
    num_lo_a: assert property ((le_rise // see [RULE15]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_NUM_LO))
        |=> st_q.fn_lo == $past(st_q.shift[15:4]) && st_q.wide == $past(st_q.shift[23]))
        else $error("numerator low word not latched");
    den_lo_a: assert property ((le_rise // see [RULE15]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_DEN_LO))
        |=> st_q.fd_lo == $past(st_q.shift[15:4]))
        else $error("denominator low word not latched");
    quarter_bit_a: assert property ((le_rise // see [RULE15]
        && addr_hit(st_q.shift, rffc_pkg::ADDR_LOCKDET))
        |=> st_q.quarter == $past(st_q.shift[13]))
        else $error("quarter-rate bit not latched");
    unmapped_a: assert property ((le_rise // see [RULE15]
        && (st_q.shift[3:0] == 4'h5 || !st_q.shift[0]))
        |=> $stable({st_q.fn_lo, st_q.fd_lo, st_q.fn_hi, st_q.fd_hi, st_q.toc, st_q.quarter}))
        else $error("unmapped word changed a register");

    // Timeout, cycle slip and lock detect decode
    no_load_a: assert property ((le_rise && st_q.toc < rffc_pkg::TOC_FL_MIN) // see [RULE5]
        |=> !st_q.load)
        else $error("fastlock started with timeout below four");
    fl_disabled_a: assert property ((st_q.toc == rffc_pkg::TOC_FLOAT // see [RULE5]
        || st_q.toc == rffc_pkg::TOC_LOW) |=> !rf_fastlock_active)
        else $error("fastlock shown while disabled");
    pin_low_a: assert property (st_q.toc == rffc_pkg::TOC_LOW |=> // see [RULE8]
        rf_fastlock_pin_oe && !rf_fastlock_pin_o && !rf_fastlock_active)
        else $error("timeout two not driving low");
    csr_off_a: assert property (st_q.cycle_slip_reduce == 2'h0 |=> // see [RULE10]
        !cycle_slip_reduce_en && cycle_slip_reduce_shift == rffc_pkg::CSR_SHIFT_OFF)
        else $error("cycle slip not disabled for code zero");
    csr_half_a: assert property (st_q.cycle_slip_reduce == 2'h1 |=> // see [RULE10]
        cycle_slip_reduce_en && cycle_slip_reduce_shift == rffc_pkg::CSR_SHIFT_HALF)
        else $error("cycle slip half rate not decoded");
    csr_quarter_a: assert property (st_q.cycle_slip_reduce == 2'h2 |=> // see [RULE10]
        cycle_slip_reduce_en && cycle_slip_reduce_shift == rffc_pkg::CSR_SHIFT_QUARTER)
        else $error("cycle slip quarter rate not decoded");
    quarter_pass_a: assert property (st_q.quarter |=> // see [RULE11]
        lockdet_tick == ($past(pd_tick) && $past(st_q.ld_div) == rffc_pkg::QUARTER_LAST))
        else $error("quarter-rate event not one in four");
    div_clear_a: assert property (!st_q.quarter |=> st_q.ld_div == 2'h0) // see [RULE11]
        else $error("lock detect divider not cleared");

    manual_c: cover property (st_q.toc == rffc_pkg::TOC_MANUAL ##1 rf_fastlock_active);
    fastlock_c: cover property (st_q.load ##[1:40] !rf_fastlock_active);
    wide_c: cover property (st_q.wide && rf_frac_numerator[21:12] != 10'h000);
    quarter_c: cover property (st_q.quarter && lockdet_tick);
endmodule // rffc_ctrl

// >>> tb/rffc_host.sv
`timescale 1ns/1ns
// Host side of the serial port: whole 24-bit words, msb first
module rffc_host (
    // Clock
    input wire logic mclk,
    // Serial lines
    output logic ser_clk,
    output logic ser_data,
    output logic ser_le
);
    // Lines idle low at time zero
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_le = 1'b0;
    end

    // Clock stands low outside frames; data released shows the inverse
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge mclk) ser_clk <= 1'b0;
            ser_data <= w[i];
            @(posedge mclk) ser_clk <= 1'b1;
        end
        @(posedge mclk) ser_clk <= 1'b0;
        ser_le <= 1'b1;
        @(posedge mclk) ser_le <= 1'b0;
        ser_data <= ~w[0];
    endtask
endmodule // rffc_host

// >>> tb/rffc_ctrl_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the fraction and fastlock control block
module rffc_ctrl_tb;
    logic mclk, rst, pd_tick, ser_clk, ser_data, ser_le;
    logic [21:0] num, den;
    logic active, csr_en, pin_o, pin_oe, ld_tick, wide;
    logic [4:0] gain;
    logic [3:0] shift;
    logic [9:0] nhi, dhi;
    logic [11:0] nlo, dlo;
    logic [13:0] tw;
    logic [31:0] rnd = 32'h00000030;
    int miscompares = 0;
    int num_checks = 0;
    int ld_count = 0;
    int base;

    // Clock at 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    rffc_host rffc_host_i (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));

    rffc_ctrl rffc_ctrl_i (
        .mclk(mclk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
        .pd_tick(pd_tick), .rf_frac_numerator(num), .rf_frac_denominator(den),
        .rf_fastlock_active(active), .rf_fastlock_pump_gain(gain),
        .cycle_slip_reduce_en(csr_en), .cycle_slip_reduce_shift(shift),
        .rf_fastlock_pin_o(pin_o), .rf_fastlock_pin_oe(pin_oe), .lockdet_tick(ld_tick)
    );

    // Count lock detect pulses
    always @(posedge mclk) begin
        if (ld_tick === 1'b1) ld_count++;
    end

    // Random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected fraction for the chosen width
    function automatic logic [21:0] exp_frac(input logic w, input logic [9:0] hi,
                                             input logic [11:0] lo);
        return w ? {hi, lo} : {10'h000, lo};
    endfunction

    // Expected sample rate shift per cycle slip code
    function automatic logic [3:0] exp_shift(input int c);
        return (c == 3) ? 4'h4 : c[3:0];
    endfunction

    // Fraction low half or frequency word
    function automatic logic [23:0] w_lo(input logic w, input logic [11:0] lo,
                                         input logic [3:0] code);
        return {w, 7'h00, lo, code};
    endfunction

    // Fastlock configuration word
    function automatic logic [23:0] w_fl(input logic [1:0] c, input logic [3:0] g,
                                         input logic [13:0] t);
        return {c, g, t, rffc_pkg::ADDR_FASTLOCK};
    endfunction

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Closing report
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One word, then let the outputs settle
    task automatic wr(input logic [23:0] w);
        rffc_host_i.send(w);
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // One comparison event
    task automatic tick();
        @(posedge mclk) pd_tick <= 1'b1;
        @(posedge mclk) pd_tick <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        pd_tick = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check("pin_oe", pin_oe, 0);
        check("active", active, 0);
        // Fractions, narrow and wide, with an unmapped word after
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            {nlo, dhi, nhi} = rnd;
            rnd = lfsr(rnd);
            dlo = rnd[11:0];
            wide = i[0];
            if (i == 3) {nhi, dhi} = 20'h00000;
            if (i == 5) {nhi, dhi, nlo, dlo} = '1;
            wr({dhi, nhi, rffc_pkg::ADDR_FRAC_HI});
            wr(w_lo(1'b0, dlo, rffc_pkg::ADDR_DEN_LO));
            wr(w_lo(wide, nlo, rffc_pkg::ADDR_NUM_LO));
            wr({rnd[31:12], 4'h5});
            check("numerator", num, exp_frac(wide, nhi, nlo));
            check("denominator", den, exp_frac(wide, dhi, dlo));
        end
        // Plain pin settings, every cycle slip code, forced fastlock gain
        for (int t = 0; t < 4; t++) begin
            for (int c = 0; c < 4; c++) begin
                rnd = lfsr(rnd);
                wr(w_fl(c[1:0], rnd[3:0], t[13:0]));
                check("pin_oe", pin_oe, t != 0);
                if (t != 0) check("pin_o", pin_o, t == 3);
                check("active", active, t == 1);
                check("gain", gain, (t == 1) ? rnd[3:0] + 1 : 0);
                check("csr_en", csr_en, c != 0);
                check("csr_shift", shift, exp_shift(c));
            end
        end
        // Timed fastlock at the shortest and a random longer timeout
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            tw = (k == 0) ? 14'h0004 : 14'h0004 + rnd[2:0];
            wr(w_fl(2'h0, rnd[7:4], tw));
            check("pin_oe", pin_oe, 1);
            check("active", active, 0);
            wr(w_lo(1'b0, 12'h000, rffc_pkg::ADDR_NUM_LO));
            for (int n = 0; n <= 2 * tw; n++) begin
                check("active", active, n < 2 * tw);
                check("pin_o", pin_o, n < 2 * tw);
                check("gain", gain, (n < 2 * tw) ? rnd[7:4] + 1 : 0);
                tick();
            end
        end
        // Lock detect events, full rate then quarter rate
        for (int q = 0; q < 2; q++) begin
            wr({10'h000, q[0], 9'h000, rffc_pkg::ADDR_LOCKDET});
            for (int n = 1; n <= 8; n++) begin
                base = ld_count;
                tick();
                check("lockdet", ld_count - base, q == 0 || n % 4 == 0);
            end
        end
        print_verdict();
    end
endmodule // rffc_ctrl_tb
